// >>> verilog/pmm_consts.svh
// offsets, field positions, reset values and keys of the power-management register bank
`ifndef PMM_CONSTS_SVH
`define PMM_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_POWER_CTL0      8'h00
`define OFF_HIGH_SUP_CTL    8'h04
`define OFF_CORE_SUP_CTL    8'h08
`define OFF_RST_IRQ_EN      8'h0C
`define OFF_IRQ_STATUS      8'h10
`define OFF_IRQ_ENABLE      8'h14
`define OFF_IRQ_CLEAR       8'h18

// ----------------------------------------------------------------
// reset values per silicon revision
// ----------------------------------------------------------------
`define CTL0_RST_EARLY      8'h02
`define CTL0_RST_LATER      8'h00
`define SUP_CTL_RST_EARLY   16'h4602
`define SUP_CTL_RST_LATER   16'h4400
`define RIE_RST_EARLY       16'h1100
`define RIE_RST_LATER       16'h0000

// ----------------------------------------------------------------
// write masks and password
// ----------------------------------------------------------------
`define CTL0_STORE_MASK     8'h93
`define SUP_CTL_WR_MASK     16'hDFD7
`define RIE_WR_MASK         16'h3377
`define PW_READ_VALUE       8'h96
`define PW_WRITE_KEY        8'hA5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTL0_COREV_LSB      0
`define CTL0_SWBOR_BIT      2
`define CTL0_SWPOR_BIT      3
`define CTL0_REGOFF_BIT     4
`define SUP_MON_EN_BIT      14
`define SUP_SVS_EN_BIT      10
`define RIE_HIGH_POR_BIT    12
`define RIE_CORE_POR_BIT    8
`define IRQ_HIGH_SVS_BIT    0
`define IRQ_HIGH_SVM_BIT    1
`define IRQ_CORE_SVS_BIT    2
`define IRQ_CORE_SVM_BIT    3
`define STATUS_UNLOCK_BIT   8

`endif

// >>> verilog/pmm_pkg.sv
// types shared by the power-management register bank
`default_nettype none
package pmm_pkg;
  typedef enum logic {
    REV_EARLY = 1'b0,
    REV_LATER = 1'b1
  } silicon_rev_t;

  typedef logic [15:0] reg16_t;
  typedef logic [3:0]  irq_t;
endpackage : pmm_pkg
`default_nettype wire

// >>> verilog/supply_watch_if.sv
// enables and events between the register bank and one supply watcher
`default_nettype none
interface supply_watch_if;
  logic svs_en;
  logic svm_en;
  logic svs_fault;
  logic svm_event;
  modport ctl (output svs_en, output svm_en, input svs_fault, input svm_event);
  modport mon (input svs_en, input svm_en, output svs_fault, output svm_event);
endinterface : supply_watch_if
`default_nettype wire

// >>> verilog/supply_watch.sv
// synchronises one supply's comparator pins and gates them by their enables
`default_nettype none
module supply_watch (
  input  wire logic    i_clk,        // core clock
  input  wire logic    i_srst,       // synchronous reset, high
  input  wire logic    i_below_svs,  // supply below supervisor threshold, async pin
  input  wire logic    i_below_svm,  // supply below monitor threshold, async pin
  supply_watch_if.mon  watch         // enables in, fault and event out
);
  logic svs_s1_ff;
  logic svs_s2_ff;
  logic svm_s1_ff;
  logic svm_s2_ff;
  logic svm_prev_ff;

  // ----------------------------------------------------------------
  // two-stage synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      svs_s1_ff <= 1'b0;
      svs_s2_ff <= 1'b0;
      svm_s1_ff <= 1'b0;
      svm_s2_ff <= 1'b0;
      svm_prev_ff <= 1'b0;
    end else begin
      svs_s1_ff <= i_below_svs;
      svs_s2_ff <= svs_s1_ff;
      svm_s1_ff <= i_below_svm;
      svm_s2_ff <= svm_s1_ff;
      svm_prev_ff <= svm_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // gated fault level and monitor crossing pulse
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      watch.svs_fault <= 1'b0;
      watch.svm_event <= 1'b0;
    end else begin
      watch.svs_fault <= watch.svs_en & svs_s2_ff;
      watch.svm_event <= watch.svm_en & svm_s2_ff & ~svm_prev_ff;
    end
  end
endmodule : supply_watch
`default_nettype wire

// >>> verilog/power_mgmt_reg_defaults.sv
// power-management control register bank with revision-dependent reset values
//
// Function
// R1 - earlier revision: core voltage level resets to 2, low byte 0x02.
// R2 - later revision: standard defaults, low byte 0x00, core level 0.
// R3 - high-side supervisor control resets 0x4602 earlier, 0x4400 later.
// R4 - high-side supervisor and monitor enables read 1 after reset.
// R5 - core-side supervisor control resets 0x4602 earlier, 0x4400 later.
// R6 - core-side supervisor and monitor enables read 1 after reset.
// R7 - reset/interrupt enable resets 0x1100 earlier, 0x0000 later.
// R8 - enabled supervisor with supply below threshold raises power-on reset; here only while its POR bit in the reset/interrupt enable is set.
// R9 - software keeps oscillator at 8 MHz or less while core level is 0.
// R10 - software steps the core level only through the prescribed procedure.
// R11 - silicon revision is a build parameter choosing the reset value set.
// R12 - power control upper byte is a password gating protected writes.
//
// Our own choices: the register offsets and register access over APB.
`include "pmm_consts.svh"
`default_nettype none
module power_mgmt_reg_defaults #(
  parameter pmm_pkg::silicon_rev_t REVISION = pmm_pkg::REV_LATER
) (
  input  wire logic        i_clk,                    // core clock, 250 MHz
  input  wire logic        i_srst,                   // synchronous reset, high
  input  wire logic        i_psel,                   // apb select
  input  wire logic        i_penable,                // apb enable
  input  wire logic        i_pwrite,                 // apb write
  input  wire logic [7:0]  i_paddr,                  // apb byte address
  input  wire logic [31:0] i_pwdata,                 // apb write data
  output logic      [31:0] o_prdata,                 // apb read data
  output logic             o_pready,                 // apb ready
  output logic             o_pslverr,                // apb error
  input  wire logic        i_high_below_svs,         // high supply under supervisor level
  input  wire logic        i_high_below_svm,         // high supply under monitor level
  input  wire logic        i_core_below_svs,         // core supply under supervisor level
  input  wire logic        i_core_below_svm,         // core supply under monitor level
  output logic      [1:0]  o_core_voltage_level,     // core level to regulator
  output logic             o_regulator_off,          // regulator off request
  output logic             o_high_supervisor_enable, // high supervisor on
  output logic             o_high_monitor_enable,    // high monitor on
  output logic             o_core_supervisor_enable, // core supervisor on
  output logic             o_core_monitor_enable,    // core monitor on
  output logic             o_por_req,                // power-on reset request
  output logic             o_bor_req,                // brownout reset request
  output logic             o_irq                     // level interrupt
);

  // ----------------------------------------------------------------
  // reset value selection
  // ----------------------------------------------------------------
  localparam logic           EARLY    = (REVISION == pmm_pkg::REV_EARLY);
  localparam logic [7:0]     CTL0_RST = EARLY ? `CTL0_RST_EARLY : `CTL0_RST_LATER;       // see R1 // see R2 // see R11
  localparam pmm_pkg::reg16_t SUP_RST = EARLY ? `SUP_CTL_RST_EARLY : `SUP_CTL_RST_LATER; // see R3 // see R5 // see R11
  localparam pmm_pkg::reg16_t RIE_RST = EARLY ? `RIE_RST_EARLY : `RIE_RST_LATER;         // see R7 // see R11

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]       ctl0_ff;
  pmm_pkg::reg16_t  high_ctl_ff;
  pmm_pkg::reg16_t  core_ctl_ff;
  pmm_pkg::reg16_t  rie_ff;
  pmm_pkg::irq_t    irq_stat_ff;
  pmm_pkg::irq_t    irq_en_ff;
  logic             unlock_ff;
  logic             pready_ff;
  logic [31:0]      prdata_ff;
  logic             pslverr_ff;
  logic             por_ff;
  logic             bor_ff;
  logic             irq_ff;

  logic             access;
  logic             wr_fire;
  logic             key_ok;
  logic             mapped;
  logic [31:0]      rd_mux;
  pmm_pkg::irq_t    irq_set;
  pmm_pkg::irq_t    irq_clr;
  pmm_pkg::irq_t    nxt_irq_stat;
  logic             ctl0_wr;
  logic             ctl0_key_wr;
  logic             high_wr;
  logic             core_wr;
  logic             rie_wr;
  logic             irq_en_wr;
  logic             irq_clr_wr;

  supply_watch_if high_if ();
  supply_watch_if core_if ();

  // ----------------------------------------------------------------
  // supply watchers
  // ----------------------------------------------------------------
  assign high_if.svs_en = high_ctl_ff[`SUP_SVS_EN_BIT];
  assign high_if.svm_en = high_ctl_ff[`SUP_MON_EN_BIT];
  assign core_if.svs_en = core_ctl_ff[`SUP_SVS_EN_BIT];
  assign core_if.svm_en = core_ctl_ff[`SUP_MON_EN_BIT];

  supply_watch u_high_watch (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_below_svs (i_high_below_svs),
    .i_below_svm (i_high_below_svm),
    .watch       (high_if.mon)
  );

  supply_watch u_core_watch (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_below_svs (i_core_below_svs),
    .i_below_svm (i_core_below_svm),
    .watch       (core_if.mon)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign access  = i_psel & i_penable;
  // a write lands on the edge where ready is sampled high
  assign wr_fire = access & i_pwrite & pready_ff;
  assign key_ok  = (i_pwdata[15:8] == `PW_WRITE_KEY);

  // ----------------------------------------------------------------
  // write strobes, one per writable register, two for power control
  // ----------------------------------------------------------------
  assign ctl0_wr     = wr_fire & (i_paddr == `OFF_POWER_CTL0);
  assign ctl0_key_wr = ctl0_wr & key_ok;
  // the three supervisor registers only take writes while unlocked
  assign high_wr     = wr_fire & unlock_ff & (i_paddr == `OFF_HIGH_SUP_CTL);  // see R12
  assign core_wr     = wr_fire & unlock_ff & (i_paddr == `OFF_CORE_SUP_CTL);  // see R12
  assign rie_wr      = wr_fire & unlock_ff & (i_paddr == `OFF_RST_IRQ_EN);    // see R12
  assign irq_en_wr   = wr_fire & (i_paddr == `OFF_IRQ_ENABLE);
  assign irq_clr_wr  = wr_fire & (i_paddr == `OFF_IRQ_CLEAR);

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `OFF_POWER_CTL0: begin
        rd_mux = {16'h0000, `PW_READ_VALUE, ctl0_ff};
      end
      `OFF_HIGH_SUP_CTL: begin
        rd_mux = {16'h0000, high_ctl_ff};
      end
      `OFF_CORE_SUP_CTL: begin
        rd_mux = {16'h0000, core_ctl_ff};
      end
      `OFF_RST_IRQ_EN: begin
        rd_mux = {16'h0000, rie_ff};
      end
      `OFF_IRQ_STATUS: begin
        rd_mux = {28'h000_0000, irq_stat_ff};
        rd_mux[`STATUS_UNLOCK_BIT] = unlock_ff;
      end
      `OFF_IRQ_ENABLE: begin
        rd_mux = {28'h000_0000, irq_en_ff};
      end
      `OFF_IRQ_CLEAR: begin
        rd_mux = 32'h0000_0000;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // apb answer, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= access & ~pready_ff;
      prdata_ff  <= (access & ~pready_ff & ~i_pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_ff <= access & ~pready_ff & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // power control and password
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctl0_ff <= CTL0_RST;                                             // see R1 // see R2
    end else if (ctl0_key_wr) begin
      ctl0_ff <= i_pwdata[7:0] & `CTL0_STORE_MASK;                     // see R12
    end
  end

  // a keyed write unlocks, any other write here locks again
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      unlock_ff <= 1'b0;
    end else if (ctl0_wr) begin
      unlock_ff <= key_ok;                                             // see R12
    end
  end

  // ----------------------------------------------------------------
  // supervisor controls, writable only while unlocked
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      high_ctl_ff <= SUP_RST;                                          // see R3 // see R4
    end else if (high_wr) begin
      high_ctl_ff <= i_pwdata[15:0] & `SUP_CTL_WR_MASK;                // see R12
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      core_ctl_ff <= SUP_RST;                                          // see R5 // see R6
    end else if (core_wr) begin
      core_ctl_ff <= i_pwdata[15:0] & `SUP_CTL_WR_MASK;                // see R12
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rie_ff <= RIE_RST;                                               // see R7
    end else if (rie_wr) begin
      rie_ff <= i_pwdata[15:0] & `RIE_WR_MASK;                         // see R12
    end
  end

  // ----------------------------------------------------------------
  // reset requests
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      por_ff <= 1'b0;
    end else begin
      por_ff <= (rie_ff[`RIE_HIGH_POR_BIT] & high_if.svs_fault)      // see R8
              | (rie_ff[`RIE_CORE_POR_BIT] & core_if.svs_fault)      // see R8
              | (ctl0_key_wr & i_pwdata[`CTL0_SWPOR_BIT]);
    end
  end

  // software brownout request, one cycle long
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bor_ff <= 1'b0;
    end else begin
      bor_ff <= ctl0_key_wr & i_pwdata[`CTL0_SWBOR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, enable and clear; set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = 4'h0;
    irq_set[`IRQ_HIGH_SVS_BIT] = high_if.svs_fault;
    irq_set[`IRQ_HIGH_SVM_BIT] = high_if.svm_event;
    irq_set[`IRQ_CORE_SVS_BIT] = core_if.svs_fault;
    irq_set[`IRQ_CORE_SVM_BIT] = core_if.svm_event;
    irq_clr = irq_clr_wr ? i_pwdata[3:0] : 4'h0;
    nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_stat_ff <= 4'h0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_en_ff <= 4'h0;
    end else if (irq_en_wr) begin
      irq_en_ff <= i_pwdata[3:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign o_prdata                 = prdata_ff;
  assign o_pready                 = pready_ff;
  assign o_pslverr                = pslverr_ff;
  // software must step the level itself and keep the clock slow at level 0
  assign o_core_voltage_level     = ctl0_ff[`CTL0_COREV_LSB +: 2];
  assign o_regulator_off          = ctl0_ff[`CTL0_REGOFF_BIT];
  assign o_high_supervisor_enable = high_ctl_ff[`SUP_SVS_EN_BIT];      // see R4
  assign o_high_monitor_enable    = high_ctl_ff[`SUP_MON_EN_BIT];      // see R4
  assign o_core_supervisor_enable = core_ctl_ff[`SUP_SVS_EN_BIT];      // see R6
  assign o_core_monitor_enable    = core_ctl_ff[`SUP_MON_EN_BIT];      // see R6
  assign o_por_req                = por_ff;
  assign o_bor_req                = bor_ff;
  assign o_irq                    = irq_ff;

endmodule : power_mgmt_reg_defaults
`default_nettype wire

// >>> bench/power_mgmt_reg_defaults_props.sv
// concurrent checks on the ports of the power-management register bank
`include "pmm_consts.svh"
`default_nettype none
module power_mgmt_reg_defaults_props #(
  parameter pmm_pkg::silicon_rev_t REVISION = pmm_pkg::REV_LATER
) (
  input wire logic        i_clk,                    // core clock
  input wire logic        i_srst,                   // sync reset
  input wire logic        i_psel,                   // apb select
  input wire logic        i_penable,                // apb enable
  input wire logic        i_pwrite,                 // apb write
  input wire logic [7:0]  i_paddr,                  // apb address
  input wire logic [31:0] i_pwdata,                 // apb write data
  input wire logic [31:0] o_prdata,                 // apb read data
  input wire logic        o_pready,                 // apb ready
  input wire logic        o_pslverr,                // apb error
  input wire logic        i_high_below_svs,         // high supervisor pin
  input wire logic        i_high_below_svm,         // high monitor pin
  input wire logic        i_core_below_svs,         // core supervisor pin
  input wire logic        i_core_below_svm,         // core monitor pin
  input wire logic [1:0]  o_core_voltage_level,     // core level
  input wire logic        o_high_supervisor_enable, // high supervisor on
  input wire logic        o_high_monitor_enable,    // high monitor on
  input wire logic        o_core_supervisor_enable, // core supervisor on
  input wire logic        o_core_monitor_enable,    // core monitor on
  input wire logic        o_por_req,                // power-on reset
  input wire logic        o_irq                     // interrupt
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic key_wr;
  logic any_low;
  assign key_wr  = o_pready && i_pwrite && i_paddr == `OFF_POWER_CTL0 && i_pwdata[15:8] == `PW_WRITE_KEY;
  assign any_low = i_high_below_svs | i_high_below_svm | i_core_below_svs | i_core_below_svm;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_access_wait;
    i_psel && i_penable && !o_pready;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_one_wait_state: assert property (s_access_wait |=> o_pready)
    else $error("ready not one cycle after access");
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  chk_err_unmapped: assert property (o_pready |-> o_pslverr == (i_paddr > `OFF_IRQ_CLEAR || i_paddr[1:0] != 2'h0))
    else $error("slave error does not match address map");
  chk_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data not zero outside answer");
  chk_reset_values: assert property ($past(i_srst) |-> o_core_voltage_level ==
    ((REVISION == pmm_pkg::REV_EARLY) ? 2'h2 : 2'h0) && o_high_supervisor_enable && o_high_monitor_enable
    && o_core_supervisor_enable && o_core_monitor_enable)
    else $error("wrong output levels after reset");
  chk_level_keyed: assert property ($changed(o_core_voltage_level) |-> $past(key_wr))
    else $error("core level changed without keyed write");
  chk_por_cause: assert property (o_por_req |-> $past(i_high_below_svs, 4) || $past(i_core_below_svs, 4)
    || $past(key_wr && i_pwdata[`CTL0_SWPOR_BIT]))
    else $error("reset request without supervisor fault or software request");
  chk_irq_cause: assert property ($rose(o_irq) |-> $past(any_low, 4)
    || $past(o_pready && i_pwrite && i_paddr == `OFF_IRQ_ENABLE, 2))
    else $error("interrupt rose without supply event or enable write");
endmodule : power_mgmt_reg_defaults_props

bind power_mgmt_reg_defaults power_mgmt_reg_defaults_props #(.REVISION(REVISION)) u_props (
  .i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
  .i_high_below_svs, .i_high_below_svm, .i_core_below_svs, .i_core_below_svm, .o_core_voltage_level,
  .o_high_supervisor_enable, .o_high_monitor_enable, .o_core_supervisor_enable, .o_core_monitor_enable,
  .o_por_req, .o_irq);
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the power-management register bank, earlier revision, with the later revision's reset values checked alongside
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [15:0] d;
    logic [15:0] e;
    logic        err;
  } row_t;
  logic        i_clk = 1'h0, i_srst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd, late_prdata, late_rd;
  logic        i_high_below_svs = 1'h0, i_high_below_svm = 1'h0;
  logic        i_core_below_svs = 1'h0, i_core_below_svm = 1'h0;
  logic        o_pready, o_pslverr, o_regulator_off, o_por_req, o_bor_req, o_irq, er;
  logic [1:0]  o_core_voltage_level, late_level;
  logic        o_high_supervisor_enable, o_high_monitor_enable, o_core_supervisor_enable, o_core_monitor_enable;
  int          fails = 0, n_checks = 0;
  row_t        rows[18] = '{
    '{8'h00, 1'h0, 16'h0000, 16'h9602, 1'h0}, '{8'h04, 1'h0, 16'h0000, 16'h4602, 1'h0},
    '{8'h08, 1'h0, 16'h0000, 16'h4602, 1'h0}, '{8'h0C, 1'h0, 16'h0000, 16'h1100, 1'h0},
    '{8'h20, 1'h0, 16'h0000, 16'h0000, 1'h1}, '{8'h04, 1'h1, 16'h0000, 16'h0000, 1'h0},
    '{8'h04, 1'h0, 16'h0000, 16'h4602, 1'h0}, '{8'h00, 1'h1, 16'hA503, 16'h0000, 1'h0},
    '{8'h00, 1'h0, 16'h0000, 16'h9603, 1'h0}, '{8'h04, 1'h1, 16'hFFFF, 16'h0000, 1'h0},
    '{8'h04, 1'h0, 16'h0000, 16'hDFD7, 1'h0}, '{8'h0C, 1'h1, 16'hFFFF, 16'h0000, 1'h0},
    '{8'h0C, 1'h0, 16'h0000, 16'h3377, 1'h0}, '{8'h0C, 1'h1, 16'h1100, 16'h0000, 1'h0},
    '{8'h00, 1'h1, 16'h1200, 16'h0000, 1'h0}, '{8'h08, 1'h1, 16'h0000, 16'h0000, 1'h0},
    '{8'h08, 1'h0, 16'h0000, 16'h4602, 1'h0}, '{8'h18, 1'h0, 16'h0000, 16'h0000, 1'h0}};

  power_mgmt_reg_defaults #(.REVISION(pmm_pkg::REV_EARLY)) DUT (
    .i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_high_below_svs, .i_high_below_svm, .i_core_below_svs, .i_core_below_svm, .o_core_voltage_level,
    .o_regulator_off, .o_high_supervisor_enable, .o_high_monitor_enable, .o_core_supervisor_enable,
    .o_core_monitor_enable, .o_por_req, .o_bor_req, .o_irq);

  power_mgmt_reg_defaults #(.REVISION(pmm_pkg::REV_LATER)) DUT_LATER (
    .i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata(late_prdata), .o_pready(),
    .o_pslverr(), .i_high_below_svs, .i_high_below_svm, .i_core_below_svs, .i_core_below_svm,
    .o_core_voltage_level(late_level), .o_regulator_off(), .o_high_supervisor_enable(), .o_high_monitor_enable(),
    .o_core_supervisor_enable(), .o_core_monitor_enable(), .o_por_req(), .o_bor_req(), .o_irq());

  always #2 i_clk = ~i_clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge i_clk);
    i_psel    <= 1'h1;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'h1);
    rd        = o_prdata;
    late_rd   = late_prdata;
    er        = o_pslverr;
    i_psel    <= 1'h0;
    i_penable <= 1'h0;
  endtask : apb

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    i_srst <= 1'h0;
    check({30'h0, o_core_voltage_level}, 32'h2);
    check({28'h0, o_high_supervisor_enable, o_high_monitor_enable, o_core_supervisor_enable,
           o_core_monitor_enable}, 32'hF);
    check({30'h0, late_level}, 32'h0);
    foreach (rows[k]) begin
      apb(rows[k].a, rows[k].w, {16'h0, rows[k].d});
      check({31'h0, er}, {31'h0, rows[k].err});
      if (!rows[k].w) check(rd, {16'h0, rows[k].e});
    end
    check({30'h0, o_core_voltage_level}, 32'h3);
    // enabled high supervisor fault: reset request and interrupt four edges on
    apb(8'h14, 1'h1, 32'h1);
    i_high_below_svs <= 1'h1;
    repeat (4) @(posedge i_clk);
    check({31'h0, o_por_req}, 32'h0);
    @(posedge i_clk);
    check({30'h0, o_por_req, o_irq}, 32'h3);
    apb(8'h10, 1'h0, 32'h0);
    check(rd & 32'hF, 32'h1);
    i_high_below_svs <= 1'h0;
    repeat (6) @(posedge i_clk);
    apb(8'h18, 1'h1, 32'hF);
    repeat (2) @(posedge i_clk);
    check({30'h0, o_por_req, o_irq}, 32'h0);
    // masked interrupt, core supervisor still resets
    apb(8'h14, 1'h1, 32'h0);
    i_core_below_svs <= 1'h1;
    repeat (5) @(posedge i_clk);
    check({30'h0, o_por_req, o_irq}, 32'h2);
    apb(8'h10, 1'h0, 32'h0);
    check(rd & 32'hF, 32'h4);
    i_core_below_svs <= 1'h0;
    // reset enables cleared: fault gives no reset request
    apb(8'h00, 1'h1, 32'hA503);
    apb(8'h0C, 1'h1, 32'h0);
    i_high_below_svs <= 1'h1;
    repeat (5) @(posedge i_clk);
    check({31'h0, o_por_req}, 32'h0);
    i_high_below_svs <= 1'h0;
    repeat (6) @(posedge i_clk);
    apb(8'h18, 1'h1, 32'hF);
    i_core_below_svm <= 1'h1;
    repeat (5) @(posedge i_clk);
    i_core_below_svm <= 1'h0;
    apb(8'h10, 1'h0, 32'h0);
    check(rd & 32'hF, 32'h8);
    // keyed write with both software resets: one-cycle pulses, level kept at 3
    apb(8'h00, 1'h1, 32'hA51F);
    @(posedge i_clk);
    check({27'h0, o_core_voltage_level, o_regulator_off, o_por_req, o_bor_req}, 32'h1F);
    @(posedge i_clk);
    check({30'h0, o_por_req, o_bor_req}, 32'h0);
    // mid-run reset returns both revisions to their own values
    i_srst <= 1'h1;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'h0;
    for (int k = 0; k < 4; k++) begin
      apb(rows[k].a, 1'h0, 32'h0);
      check(rd, {16'h0, rows[k].e});
      check(late_rd, (k == 0) ? 32'h9600 : (k == 3) ? 32'h0000_0000 : 32'h4400);
    end
    apb(8'h10, 1'h0, 32'h0);
    check(rd, 32'h0);
    tally_and_finish();
  end

  initial begin
    repeat (2000) @(posedge i_clk);
    fails++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
